// file: design/dpbg_pkg.sv
// Purpose: Shared constants and types for the dual-port buffer guard.
// Assumes: One clock (mclk, 25 MHz), synchronous active-high reset.
// Notes:   Address widths are module parameters; only codes live here.
`default_nettype none
package dpbg_pkg;
  // ==========================================================================
  // Modes and buffer indices
  // ==========================================================================
  localparam logic       MODE_MAILBOX  = 1'b0;
  localparam logic       MODE_BUFFERED = 1'b1;
  localparam int         NUM_AREAS     = 3;
  localparam logic [1:0] AREA_RESET_W  = 2'h0;
  localparam logic [1:0] AREA_RESET_R  = 2'h1;
  localparam logic [1:0] AREA_RESET_S  = 2'h2;

  // Mailbox handshake states
  typedef enum logic [0:0] {
    DPBG_MB_EMPTY = 1'b0,
    DPBG_MB_FULL  = 1'b1
  } dpbg_mb_t;
endpackage
`default_nettype wire

// file: design/dpbg_guard.sv
// Purpose: Buffer guard between a network-side port (through the logical address mapper)
//          and a local host port, over one dual-port memory; mailbox or three-buffer mode.
// Assumes: Network side writes, host side reads; both sides are on mclk; a network write
//          carries a commit strobe that is low when the frame check sequence failed.
// Notes:   Writes are staged per frame and only reach memory when committed.
`default_nettype none

// Function
// - The guard runs as a single-buffer mailbox or as an always-open buffered mode, chosen by an input.
// - In mailbox mode a side may use the buffer only after the other side has finished its access.
// - In mailbox mode, once the buffer is written, writes are refused until the reader has read its last byte.
// - In buffered mode both sides may access at any moment without waiting.
// - In buffered mode the writer may always write new content, read or not.
// - When the writer outpaces the reader, the older unread complete buffer is dropped, never stalling.
// - In buffered mode a read returns the held buffer, switched to the newest complete one after its last byte is read, never a partial one.
// - Buffered mode uses three equal areas of the block size, rotated between writer and reader.
// - Network accesses pass the address mapper first, then the guard, then the memory.
// - The mapper turns logical process image addresses into local physical memory addresses.
// - Data from a frame whose check sequence failed is not committed to memory.
module dpbg_guard
  import dpbg_pkg::*;
#(
  parameter int AW    = 6,    // Bytes per block = 2**AW
  parameter int LAW   = 16,   // Logical address width
  parameter int PAW   = 8     // Physical address width
) (
  // Clock and reset
  input  wire logic           mclk,
  input  wire logic           rst,
  // Configuration
  input  wire logic           mode_sel,
  input  wire logic [LAW-1:0] map_log_base,
  input  wire logic [PAW-1:0] map_phys_base,
  // Network side write port (logical addresses)
  input  wire logic           net_wr,
  input  wire logic [LAW-1:0] net_addr,
  input  wire logic [7:0]     net_wdata,
  input  wire logic           net_frame_end,
  input  wire logic           net_fcs_ok,
  // Host side read port (offset into block)
  input  wire logic           host_rd,
  input  wire logic [AW-1:0]  host_addr,
  // Results
  output logic                net_wr_refused,
  output logic                host_rd_valid,
  output logic [7:0]          host_rdata,
  output logic                host_rd_refused,
  output logic                mb_full,
  output logic [1:0]          rd_area
);
  localparam int BLK = 1 << AW;
  localparam logic [AW-1:0] LAST = AW'(BLK - 1);

  // ==========================================================================
  // Storage: three areas plus a per-frame staging copy
  // ==========================================================================
  logic [7:0] mem_reg [NUM_AREAS*BLK];
  logic [7:0] stage_reg [BLK];

  // ==========================================================================
  // Address mapping
  // ==========================================================================
  // Logical to physical translation, then window check against one block
  function automatic logic [PAW-1:0] map_addr(input logic [LAW-1:0] la,
                                              input logic [LAW-1:0] lb,
                                              input logic [PAW-1:0] pb);
    map_addr = pb + PAW'(la - lb);
  endfunction

  wire logic [LAW-1:0] log_off  = net_addr - map_log_base;
  wire logic           in_win   = (net_addr >= map_log_base) && (log_off < LAW'(BLK));
  wire logic [PAW-1:0] phys     = map_addr(net_addr, map_log_base, map_phys_base);
  wire logic [AW-1:0]  blk_off  = phys[AW-1:0] - map_phys_base[AW-1:0];

  // ==========================================================================
  // State
  // ==========================================================================
  dpbg_mb_t   mb_reg, mb_next;
  logic [1:0] w_area_reg, r_area_reg, s_area_reg;
  logic       s_new_reg;
  logic       last_seen_reg;   // Last byte of area written in this frame
  logic       rd_last_reg;     // Host read the last byte of the held area
  logic       host_rd_valid_reg, net_wr_refused_reg, host_rd_refused_reg;
  logic [7:0] host_rdata_reg;

  // Access permission decode
  wire logic mb_mode   = (mode_sel == MODE_MAILBOX);
  wire logic wr_ok     = mb_mode ? (mb_reg == DPBG_MB_EMPTY) : 1'b1;
  wire logic rd_ok     = mb_mode ? (mb_reg == DPBG_MB_FULL) : 1'b1;
  wire logic wr_take   = net_wr && in_win && wr_ok;
  wire logic rd_take   = host_rd && rd_ok;
  wire logic wr_last   = wr_take && (blk_off == LAST);
  wire logic complete  = net_frame_end && net_fcs_ok && (last_seen_reg || wr_last);
  wire logic mb_read_done = mb_mode && rd_take && (host_addr == LAST);
  wire logic [1:0] cmt_area = mb_mode ? AREA_RESET_W : w_area_reg;
  wire logic [1:0] rd_src   = mb_mode ? AREA_RESET_W : r_area_reg;

  // Mailbox next state: fill on commit, empty on final read
  always_comb begin
    mb_next = mb_reg;
    case (mb_reg)
      DPBG_MB_EMPTY: if (mb_mode && complete) mb_next = DPBG_MB_FULL;
      DPBG_MB_FULL:  if (mb_read_done) mb_next = DPBG_MB_EMPTY;
      default:       mb_next = DPBG_MB_EMPTY;
    endcase
  end

  // Staging writes; nothing reaches memory before a good frame end
  always_ff @(posedge mclk) begin
    if (wr_take) begin
      stage_reg[blk_off] <= net_wdata;
    end
  end

  // Commit staged frame into the writer's area
  always_ff @(posedge mclk) begin
    if (complete) begin
      for (int i = 0; i < BLK; i++) begin
        mem_reg[int'(cmt_area)*BLK + i] <= (wr_take && blk_off == AW'(i)) ? net_wdata : stage_reg[i];
      end
    end
  end

  // Frame progress and mailbox state
  always_ff @(posedge mclk) begin
    if (rst) begin
      mb_reg        <= DPBG_MB_EMPTY;
      last_seen_reg <= 1'b0;
    end else begin
      mb_reg        <= mb_next;
      last_seen_reg <= net_frame_end ? 1'b0 : (last_seen_reg | wr_last);
    end
  end

  // Three-buffer rotation: writer, reader and spare (newest) areas
  always_ff @(posedge mclk) begin
    if (rst) begin
      w_area_reg  <= AREA_RESET_W;
      r_area_reg  <= AREA_RESET_R;
      s_area_reg  <= AREA_RESET_S;
      s_new_reg   <= 1'b0;
      rd_last_reg <= 1'b0;
    end else if (!mb_mode) begin
      // A commit in the same cycle wins; keep the reader's request so the switch waits a cycle instead of being lost
      rd_last_reg <= (rd_take && (host_addr == LAST)) || (rd_last_reg && complete);
      if (complete) begin
        w_area_reg <= s_area_reg;
        s_area_reg <= w_area_reg;
        s_new_reg  <= 1'b1;
      end else if (rd_last_reg && s_new_reg) begin
        r_area_reg <= s_area_reg;
        s_area_reg <= r_area_reg;
        s_new_reg  <= 1'b0;
      end
    end
  end

  // Host read data and refusal flags
  always_ff @(posedge mclk) begin
    if (rst) begin
      host_rd_valid_reg   <= 1'b0;
      host_rdata_reg      <= 8'h00;
      net_wr_refused_reg  <= 1'b0;
      host_rd_refused_reg <= 1'b0;
    end else begin
      host_rd_valid_reg   <= rd_take;
      net_wr_refused_reg  <= net_wr && in_win && !wr_ok;
      host_rd_refused_reg <= host_rd && !rd_ok;
      if (rd_take) begin
        host_rdata_reg <= mem_reg[int'(rd_src)*BLK + int'(host_addr)];
      end
    end
  end

  assign host_rd_valid   = host_rd_valid_reg;
  assign host_rdata      = host_rdata_reg;
  assign net_wr_refused  = net_wr_refused_reg;
  assign host_rd_refused = host_rd_refused_reg;
  assign mb_full         = (mb_reg == DPBG_MB_FULL);
  assign rd_area         = r_area_reg;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  property p_mb_refuse;
    @(posedge mclk) disable iff (rst) (mb_mode && mb_reg == DPBG_MB_FULL && net_wr && in_win) |=> net_wr_refused;
  endproperty
  a_mb_refuse: assert property (p_mb_refuse) else $error("Mailbox full write not refused");

  property p_mb_rd_wait;
    @(posedge mclk) disable iff (rst) (mb_mode && mb_reg == DPBG_MB_EMPTY && host_rd) |=> !host_rd_valid && host_rd_refused;
  endproperty
  a_mb_rd_wait: assert property (p_mb_rd_wait) else $error("Mailbox read granted while empty");

  property p_buf_rd_open;
    @(posedge mclk) disable iff (rst) (!mb_mode && host_rd) |=> host_rd_valid;
  endproperty
  a_buf_rd_open: assert property (p_buf_rd_open) else $error("Buffered read not served");

  property p_buf_wr_open;
    @(posedge mclk) disable iff (rst) (!mb_mode && net_wr) |=> !net_wr_refused;
  endproperty
  a_buf_wr_open: assert property (p_buf_wr_open) else $error("Buffered write refused");

  property p_swap;
    @(posedge mclk) disable iff (rst) (!mb_mode && complete) |=> s_new_reg && s_area_reg == $past(w_area_reg);
  endproperty
  a_swap: assert property (p_swap) else $error("Completed buffer not offered");

  property p_distinct;
    @(posedge mclk) disable iff (rst) (w_area_reg != r_area_reg) && (w_area_reg != s_area_reg) && (r_area_reg != s_area_reg);
  endproperty
  a_distinct: assert property (p_distinct) else $error("Areas overlap");

  property p_bad_fcs;
    @(posedge mclk) disable iff (rst) (mb_mode && mb_reg == DPBG_MB_EMPTY && net_frame_end && !net_fcs_ok) |=> mb_reg == DPBG_MB_EMPTY;
  endproperty
  a_bad_fcs: assert property (p_bad_fcs) else $error("Bad frame handed over");

  property p_partial;
    @(posedge mclk) disable iff (rst) (mb_mode && mb_reg == DPBG_MB_EMPTY && net_frame_end && !last_seen_reg && !wr_last) |=> !mb_full;
  endproperty
  a_partial: assert property (p_partial) else $error("Partial buffer handed over");

  property p_map;
    @(posedge mclk) disable iff (rst) (net_wr && in_win) |-> blk_off == log_off[AW-1:0];
  endproperty
  a_map: assert property (p_map) else $error("Mapped address wrong");
endmodule
`default_nettype wire

// file: bench/dpbg_partner.sv
// Purpose: Network-side frame writer model for the buffer guard bench.
// Assumes: One clock; one byte per cycle to consecutive logical addresses.
// Notes:   Address and data toggle between frames so stale values never match.
`default_nettype none
module dpbg_partner
  import dpbg_pkg::*;
(
  // Clock
  input  wire logic        mclk,
  // Frame request from the bench
  input  wire logic        go,
  input  wire logic [7:0]  pat,
  input  wire logic [6:0]  len,
  input  wire logic        good,
  input  wire logic [15:0] base,
  output var  logic        busy,
  // Network write port
  output var  logic        net_wr,
  output var  logic [15:0] net_addr,
  output var  logic [7:0]  net_wdata,
  output var  logic        net_frame_end,
  output var  logic        net_fcs_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] idx = 7'h00;

  // ==========================================================================
  // Quiet start, then one byte per cycle with the check result on the last
  initial begin
    {busy, net_wr, net_frame_end, net_fcs_ok} = 4'h0;
    net_addr = 16'h0000;
    net_wdata = 8'h00;
  end
  always @(posedge mclk) begin
    net_wr        <= 1'b0;
    net_frame_end <= 1'b0;
    net_fcs_ok    <= 1'b0;
    net_wdata     <= ~net_wdata;
    net_addr      <= ~net_addr;
    if (go && !busy) begin
      busy <= 1'b1;
      idx  <= 7'h00;
    end else if (busy) begin
      net_wr    <= 1'b1;
      net_addr  <= base + {9'h000, idx};
      net_wdata <= pat + {1'b0, idx};
      idx       <= idx + 7'h01;
      if (idx == len - 7'h01) begin
        net_frame_end <= 1'b1;
        net_fcs_ok    <= good;
        busy          <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/dpbg_guard_tb.sv
// Purpose: Self-checking bench for the buffer guard in both modes.
// Assumes: Default block size of 64 bytes; partner writes whole or partial frames.
// Notes:   Reads are queued as notes and matched by a monitor on the outputs.
`default_nettype none
module dpbg_guard_tb
  import dpbg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] LBASE = 16'h4c40;
  logic        mclk = 1'b0, rst = 1'b1, mode_sel = MODE_MAILBOX;
  logic        go = 1'b0, good = 1'b0, host_rd = 1'b0;
  logic [7:0]  pat = 8'h00, pa, host_rdata, net_wdata;
  logic [6:0]  len = 7'h40;
  logic [5:0]  host_addr = 6'h00;
  logic        busy, net_wr, net_frame_end, net_fcs_ok, net_wr_refused, host_rd_valid, host_rd_refused, mb_full;
  logic [15:0] net_addr;
  logic [1:0]  rd_area;
  logic [8:0]  e;
  logic [8:0]  exp_q[$];
  int          fail_count = 0, checked = 0, nref = 0, href = 0, i;
  integer      seed = 32'h80a8c335;

  always #20 mclk = ~mclk;

  dpbg_partner dpbg_partner_inst (.mclk(mclk), .go(go), .pat(pat), .len(len), .good(good), .base(LBASE),
    .busy(busy), .net_wr(net_wr), .net_addr(net_addr), .net_wdata(net_wdata),
    .net_frame_end(net_frame_end), .net_fcs_ok(net_fcs_ok));
  dpbg_guard dpbg_guard_inst (.mclk(mclk), .rst(rst), .mode_sel(mode_sel), .map_log_base(LBASE),
    .map_phys_base(8'h80), .net_wr(net_wr), .net_addr(net_addr), .net_wdata(net_wdata),
    .net_frame_end(net_frame_end), .net_fcs_ok(net_fcs_ok), .host_rd(host_rd), .host_addr(host_addr),
    .net_wr_refused(net_wr_refused), .host_rd_valid(host_rd_valid), .host_rdata(host_rdata),
    .host_rd_refused(host_rd_refused), .mb_full(mb_full), .rd_area(rd_area));

  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic frame(input logic [7:0] p, input logic [6:0] n, input logic g);
    int k;
    @(posedge mclk);
    go <= 1'b1;
    pat <= p;
    len <= n;
    good <= g;
    @(posedge mclk);
    go <= 1'b0;
    @(posedge mclk);
    for (k = 0; k < 200 && busy === 1'b1; k++) @(posedge mclk);
    repeat (3) @(posedge mclk);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] x, input logic c);
    @(posedge mclk);
    host_rd <= 1'b1;
    host_addr <= a;
    exp_q.push_back({c, x});
    @(posedge mclk);
    host_rd <= 1'b0;
  endtask
  task automatic rdall(input logic [7:0] p);
    for (int j = 0; j < 64; j++) rd(j[5:0], p + j[7:0], 1'b1);
  endtask

  // Monitor: counts refusals and matches each read answer to the oldest note
  always @(posedge mclk) begin
    if (net_wr_refused === 1'b1) nref++;
    if (host_rd_refused === 1'b1) href++;
    if (host_rd_valid === 1'b1 || host_rd_refused === 1'b1) begin
      if (exp_q.size() == 0) chk(8'h01, 8'h00);
      else begin
        e = exp_q.pop_front();
        if (e[8]) chk(host_rdata, e[7:0]);
      end
    end
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    summarize();
  end

  // Main sequence: mailbox, then three-buffer mode
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    pa = $random(seed);
    frame(pa, 7'h40, 1'b1);
    chk({7'h0, mb_full}, 8'h01);
    nref = 0;
    frame(~pa, 7'h40, 1'b1);
    chk(8'(nref), 8'h40);
    for (i = 0; i < 63; i++) rd(i[5:0], pa + i[7:0], 1'b1);
    chk({7'h0, mb_full}, 8'h01);
    rd(6'h3f, pa + 8'h3f, 1'b1);
    repeat (3) @(posedge mclk);
    chk({7'h0, mb_full}, 8'h00);
    rd(6'h00, 8'h00, 1'b0);
    repeat (3) @(posedge mclk);
    chk(8'(href), 8'h01);
    frame(pa, 7'h40, 1'b0);
    chk({7'h0, mb_full}, 8'h00);
    $display("test mailbox done");
    mode_sel <= MODE_BUFFERED;
    href = 0;
    nref = 0;
    pa = $random(seed);
    frame(~pa, 7'h40, 1'b1);
    frame(pa, 7'h40, 1'b1);
    chk(8'(nref), 8'h00);
    rd(6'h3f, 8'h00, 1'b0);
    repeat (3) @(posedge mclk);
    chk({6'h0, rd_area}, {6'h0, AREA_RESET_S});
    rdall(pa);
    frame(~pa, 7'h20, 1'b1);
    frame(pa ^ 8'h5a, 7'h40, 1'b0);
    rd(6'h3f, 8'h00, 1'b0);
    rdall(pa);
    repeat (3) @(posedge mclk);
    chk(8'(href), 8'h00);
    chk({6'h0, rd_area}, {6'h0, AREA_RESET_S});
    $display("test buffered done");
    summarize();
  end
endmodule
`default_nettype wire
